// >>> src/fuel_defs.svh
/*
  Constants of the fuel totalizer and scan selector: register offsets,
  control bit positions, reset values and timing counts.
  Assumes a 100 MHz clock and a 32-bit word-aligned register port.
*/
`ifndef FUEL_DEFS_SVH
`define FUEL_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define A_CTRL 8'h00
`define A_MAIN 8'h04
`define A_AUX 8'h08
`define A_PPT 8'h0c
`define A_RATE 8'h10
`define A_LEFT 8'h14
`define A_USED 8'h18
`define A_STAT 8'h1c
`define A_FLOW 8'h20
`define A_TTE 8'h24

// ----------------------------------------
// Control bits and reset values
// ----------------------------------------
`define C_TRIP_TOTALIZER_SETTING 0
`define C_CDT 1
`define C_NAV 2
`define C_WPT 3
`define C_DOWN 4
`define C_AUTO 5
`define CTRL_RST 6'h00
`define MAIN_RST 16'h0000
`define AUX_RST 16'h0000
`define PPT_RST 16'h0001
`define RATE_RST 4'h4
`define NUM_PARAM 21

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 32'h0000000a
`define TICK_NS 32'h000f4240
`define FUEL_MSG_MS 13'h03e8
`define ZERO_HOLD_MS 13'h1388
`define RPT_DELAY_MS 13'h01f4
`define RPT_MS 13'h00c8
`define FLOW_WIN_MS 13'h03e8
`define SEC_MS 13'h03e8
`define SEC_PER_HR 32'h00000e10
`define SEC_PER_MIN 32'h0000003c
`define MIN_PER_HR 32'h0000003c
`define MAX_HRS 32'h00000063

`endif

// >>> src/fuel_pkg.sv
/*
  Types of the fuel totalizer and scan selector.
  Assumes the constants header is compiled alongside.
*/
package fuel_pkg;
  typedef enum logic [1:0] {UI_FUEL = 2'b00, UI_QUERY = 2'b01, UI_RUN = 2'b10} ui_t;
  typedef enum logic [1:0] {CH_NO = 2'b00, CH_MAIN = 2'b01, CH_BOTH = 2'b10,
                            CH_PLUS = 2'b11} choice_t;
  typedef enum logic [2:0] {MSG_NONE = 3'b000, MSG_FUEL = 3'b001, MSG_FILL = 3'b010,
                            MSG_ZEROED = 3'b011} msg_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic [4:0] param;
    logic [15:0] value;
    logic [2:0] cyl;
    logic dot;
    logic flash;
    logic alarm;
    msg_t msg;
    choice_t choice;
  } disp_t;
endpackage : fuel_pkg

// >>> src/fuel_totalizer_scan_select.sv
/*
  Fuel totalizer, refuel prompt and digital scan selector.
  Assumes buttons and select switch are raw pins, alarm and sensor values
  come from logic on the same clock, and the register master never waits.
*/
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fuel_defs.svh"
module fuel_totalizer_scan_select
  import fuel_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire bus_req_t BUS_I,
  output logic [31:0] RDATA_O,
  input wire logic FLOW_PULSE_I,
  input wire logic STEP_BTN_I,
  input wire logic SECOND_BTN_I,
  input wire logic [1:0] SELECT_POS_I,
  input wire logic ALARM_I,
  input wire logic [4:0] ALARM_CODE_I,
  input wire logic [71:0] EGT_I,
  input wire logic [47:0] COOL_I,
  output disp_t DISP_O
);
  localparam int NP = `NUM_PARAM;
  localparam int P_DIF = 6;
  localparam int P_CRB = 5;
  localparam int P_REQ = 9;
  localparam int P_RES = 10;
  localparam int P_MPG = 11;
  localparam int P_TTE = 12;
  localparam int P_FF = 13;
  localparam int P_USD = 14;
  localparam int P_REM = 8;
  localparam int P_CLD = 20;
  // Allowed switch positions per parameter: bit0 temp, bit1 all, bit2 flow
  localparam logic [2:0] SW_MASK [NP] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3,
    3'h7, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3};

  // ----------------------------------------
  // Pin synchronisers and filters
  // ----------------------------------------
  logic [4:0] raw, s1, s2, s3, filt, filt_d;
  assign raw = {SELECT_POS_I, SECOND_BTN_I, STEP_BTN_I, FLOW_PULSE_I};
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s1 <= 5'h00;
      s2 <= 5'h00;
      s3 <= 5'h00;
      filt_d <= 5'h00;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      filt_d <= filt;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_filt
      always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) filt[gi] <= 1'b0;
        else if (s2[gi] == s3[gi]) filt[gi] <= s3[gi];
      end
    end
  endgenerate
  logic step_held, sec_held, step_tap, sec_tap, pulse_edge;
  logic [1:0] sel;
  assign step_held = filt[1];
  assign sec_held = filt[2];
  assign sel = filt[4:3];
  assign pulse_edge = filt[0] & ~filt_d[0];
  // A press while the other button is down belongs to a two-button hold
  assign step_tap = filt[1] & ~filt_d[1] & ~sec_held;
  assign sec_tap = filt[2] & ~filt_d[2] & ~step_held;

  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  logic [19:0] tick_cnt;
  logic tick;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tick_cnt <= 20'h00000;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 20'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 20'(TICK_CYCLES - 1)) ? 20'h00000 : tick_cnt + 20'h00001;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [5:0] ctrl;
  logic [15:0] main_q, aux_q, ppt, fuel_left, consumed, burned, flow_pps, edit, tte;
  logic [3:0] rate;
  ui_t ui;
  choice_t choice;
  logic [4:0] param;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl <= `CTRL_RST;
      main_q <= `MAIN_RST;
      aux_q <= `AUX_RST;
      ppt <= `PPT_RST;
      rate <= `RATE_RST;
    end else if (BUS_I.wr) begin
      unique case (BUS_I.addr)
        `A_CTRL: ctrl <= BUS_I.wdata[5:0];
        `A_MAIN: main_q <= BUS_I.wdata[15:0];
        `A_AUX: aux_q <= BUS_I.wdata[15:0];
        `A_PPT: ppt <= (BUS_I.wdata[15:0] == 16'h0000) ? 16'h0001 : BUS_I.wdata[15:0];
        `A_RATE: rate <= BUS_I.wdata[3:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) RDATA_O <= 32'h00000000;
    else if (BUS_I.rd) begin
      unique case (BUS_I.addr)
        `A_CTRL: RDATA_O <= {26'h0000000, ctrl};
        `A_MAIN: RDATA_O <= {16'h0000, main_q};
        `A_AUX: RDATA_O <= {16'h0000, aux_q};
        `A_PPT: RDATA_O <= {16'h0000, ppt};
        `A_RATE: RDATA_O <= {28'h0000000, rate};
        `A_LEFT: RDATA_O <= {16'h0000, fuel_left};
        `A_USED: RDATA_O <= {16'h0000, consumed};
        `A_STAT: RDATA_O <= {21'h000000, sel, param, choice, ui};
        `A_FLOW: RDATA_O <= {16'h0000, flow_pps};
        `A_TTE: RDATA_O <= {16'h0000, tte};
        default: RDATA_O <= 32'h00000000;
      endcase
    end else RDATA_O <= 32'h00000000;
  end

  // ----------------------------------------
  // Pulse counting and flow
  // ----------------------------------------
  logic [15:0] pcnt, win_pulses;
  logic [12:0] win_ms;
  logic unit_evt;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pcnt <= 16'h0000;
      unit_evt <= 1'b0;
    end else begin
      unit_evt <= pulse_edge && (pcnt + 16'h0001 >= ppt);
      if (pulse_edge) pcnt <= (pcnt + 16'h0001 >= ppt) ? 16'h0000 : pcnt + 16'h0001;
    end
  end
  // Pulse rate over a one-second window stands for flow rate
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      win_ms <= 13'h0000;
      win_pulses <= 16'h0000;
      flow_pps <= 16'h0000;
    end else if (tick && win_ms == `FLOW_WIN_MS - 13'h0001) begin
      win_ms <= 13'h0000;
      flow_pps <= win_pulses + {15'h0000, pulse_edge};
      win_pulses <= 16'h0000;
    end else begin
      if (tick) win_ms <= win_ms + 13'h0001;
      if (pulse_edge && win_pulses != 16'hffff) win_pulses <= win_pulses + 16'h0001;
    end
  end

  // ----------------------------------------
  // Refuel prompt
  // ----------------------------------------
  logic [12:0] msg_ms, hold_ms, rpt_ms, both_ms, sec_ms;
  logic sec_rpt, apply, adj, zero_evt, zero_shown;
  logic [16:0] both_sum;
  logic [15:0] fill_val, sub;
  assign apply = (ui == UI_QUERY) && step_tap && (choice != CH_NO);
  assign adj = (ui == UI_QUERY) && (choice == CH_PLUS) && (sec_tap || sec_rpt);
  assign both_sum = {1'b0, main_q} + {1'b0, aux_q};
  assign sub = burned + {15'h0000, unit_evt};
  always_comb begin
    fill_val = 16'h0000;
    unique case (choice)
      CH_MAIN: fill_val = main_q;
      CH_BOTH: fill_val = both_sum[16] ? 16'hffff : both_sum[15:0];
      CH_PLUS: fill_val = edit;
      CH_NO: fill_val = fuel_left;
    endcase
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ui <= UI_FUEL;
      choice <= CH_NO;
      msg_ms <= 13'h0000;
    end else begin
      unique case (ui)
        UI_FUEL: begin
          if (tick) msg_ms <= msg_ms + 13'h0001;
          if (tick && msg_ms == `FUEL_MSG_MS - 13'h0001) begin
            ui <= UI_QUERY;
            choice <= CH_NO;
          end
        end
        UI_QUERY: begin
          if (step_tap) ui <= UI_RUN;
          else if (sec_tap && choice != CH_PLUS) choice <= choice_t'(choice + 2'b01);
        end
        UI_RUN: ;
        default: ui <= UI_RUN;
      endcase
    end
  end
  // Second button auto-repeat for partial entry
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hold_ms <= 13'h0000;
      rpt_ms <= 13'h0000;
      sec_rpt <= 1'b0;
    end else begin
      sec_rpt <= 1'b0;
      if (!sec_held || step_held) begin
        hold_ms <= 13'h0000;
        rpt_ms <= 13'h0000;
      end else if (tick) begin
        if (hold_ms != `RPT_DELAY_MS) hold_ms <= hold_ms + 13'h0001;
        else if (rpt_ms == `RPT_MS - 13'h0001) begin
          rpt_ms <= 13'h0000;
          sec_rpt <= 1'b1;
        end else rpt_ms <= rpt_ms + 13'h0001;
      end
    end
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) edit <= 16'h0000;
    else if (ui == UI_QUERY && sec_tap && choice == CH_BOTH) edit <= fuel_left;
    else if (adj && ctrl[`C_DOWN]) edit <= (edit == 16'h0000) ? edit : edit - 16'h0001;
    else if (adj) edit <= (edit == 16'hffff) ? edit : edit + 16'h0001;
  end

  // ----------------------------------------
  // Totals
  // ----------------------------------------
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) fuel_left <= 16'h0000;
    else if (apply && choice == CH_PLUS) fuel_left <= fill_val;
    else if (apply) fuel_left <= (fill_val > sub) ? fill_val - sub : 16'h0000;
    else if (unit_evt && fuel_left != 16'h0000) fuel_left <= fuel_left - 16'h0001;
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) burned <= 16'h0000;
    else if (apply) burned <= 16'h0000;
    else if (unit_evt && burned != 16'hffff) burned <= burned + 16'h0001;
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) consumed <= 16'h0000;
    else if (zero_evt || (apply && !ctrl[`C_TRIP_TOTALIZER_SETTING])) consumed <= {15'h0000, unit_evt};
    else if (unit_evt && consumed != 16'hffff) consumed <= consumed + 16'h0001;
  end
  // Two-button hold on the used display
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      both_ms <= 13'h0000;
      zero_evt <= 1'b0;
      zero_shown <= 1'b0;
    end else begin
      zero_evt <= 1'b0;
      if (!(step_held && sec_held && ui == UI_RUN && param == 5'(P_USD))) both_ms <= 13'h0000;
      else if (tick && both_ms != `ZERO_HOLD_MS) begin
        both_ms <= both_ms + 13'h0001;
        zero_evt <= (both_ms == `ZERO_HOLD_MS - 13'h0001);
      end
      if (zero_evt) zero_shown <= 1'b1;
      else if (step_tap || param != 5'(P_USD)) zero_shown <= 1'b0;
    end
  end

  // ----------------------------------------
  // Scan selection
  // ----------------------------------------
  // Only the digital scan and the status register read the select switch
  logic [1:0] pos;
  logic [NP-1:0] allowed;
  assign pos = (sel == 2'b00) ? 2'd0 : (sel == 2'b10) ? 2'd2 : 2'd1;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_allow
      assign allowed[gi] = SW_MASK[gi][pos]
        && !(gi == P_CRB && ctrl[`C_CDT])
        && !((gi == P_REQ || gi == P_RES) && !(ctrl[`C_NAV] && ctrl[`C_WPT]))
        && !(gi == P_MPG && !ctrl[`C_NAV]);
    end
  endgenerate
  function automatic logic [4:0] next_param(input logic [4:0] cur, input logic [NP-1:0] ok);
    logic [4:0] r;
    int j;
    r = cur;
    for (int k = NP; k >= 1; k--) begin
      j = (int'(cur) + k) % NP;
      if (ok[j]) r = 5'(j);
    end
    return r;
  endfunction : next_param
  logic [3:0] scan_sec;
  logic adv;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sec_ms <= 13'h0000;
      scan_sec <= 4'h0;
      adv <= 1'b0;
    end else begin
      adv <= 1'b0;
      if (tick) sec_ms <= (sec_ms == `SEC_MS - 13'h0001) ? 13'h0000 : sec_ms + 13'h0001;
      if (step_tap || ui != UI_RUN) scan_sec <= 4'h0;
      else if (tick && sec_ms == `SEC_MS - 13'h0001 && ctrl[`C_AUTO] && rate != 4'h0) begin
        scan_sec <= (scan_sec == rate - 4'h1) ? 4'h0 : scan_sec + 4'h1;
        adv <= (scan_sec == rate - 4'h1);
      end
    end
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) param <= 5'h00;
    else if (ui == UI_RUN && (step_tap || adv || !allowed[param]))
      param <= next_param(param, allowed);
  end

  // ----------------------------------------
  // Derived parameters
  // ----------------------------------------
  logic [11:0] egt [6];
  logic [7:0] cool [6];
  generate
    for (gi = 0; gi < 6; gi++) begin : g_cyl
      assign egt[gi] = EGT_I[gi*12 +: 12];
      assign cool[gi] = COOL_I[gi*8 +: 8];
    end
  endgenerate
  logic [11:0] emax, emin, mean;
  logic [14:0] esum;
  logic [7:0] cmax;
  logic [2:0] imax, imin, icool, idev;
  always_comb begin
    emax = egt[0];
    emin = egt[0];
    imax = 3'h0;
    imin = 3'h0;
    esum = {3'h0, egt[0]};
    cmax = cool[0];
    icool = 3'h0;
    for (int c = 1; c < 6; c++) begin
      esum = esum + {3'h0, egt[c]};
      if (egt[c] > emax) begin
        emax = egt[c];
        imax = 3'(c);
      end
      if (egt[c] < emin) begin
        emin = egt[c];
        imin = 3'(c);
      end
      if (cool[c] > cmax) begin
        cmax = cool[c];
        icool = 3'(c);
      end
    end
    mean = 12'(esum / 15'h0006);
    idev = ((emax - mean) >= (mean - emin)) ? imax : imin;
  end
  logic [31:0] tte_s, hrs, mins;
  always_comb begin
    tte_s = (flow_pps == 16'h0000) ? 32'h00000000
          : (32'(fuel_left) * 32'(ppt)) / 32'(flow_pps);
    hrs = tte_s / `SEC_PER_HR;
    mins = (tte_s / `SEC_PER_MIN) % `MIN_PER_HR;
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) tte <= 16'h0000;
    else tte <= {(hrs > `MAX_HRS) ? 8'h63 : hrs[7:0], mins[7:0]};
  end

  // ----------------------------------------
  // Display
  // ----------------------------------------
  disp_t next_disp;
  always_comb begin
    next_disp = '0;
    next_disp.param = param;
    next_disp.choice = choice;
    unique case (ui)
      UI_FUEL: next_disp.msg = MSG_FUEL;
      UI_QUERY: begin
        next_disp.msg = MSG_FILL;
        next_disp.flash = 1'b1;
        next_disp.value = fill_val;
      end
      default: begin
        if (zero_shown) next_disp.msg = MSG_ZEROED;
        unique case (int'(param))
          P_REM: next_disp.value = fuel_left;
          P_TTE: next_disp.value = tte;
          P_FF: next_disp.value = flow_pps;
          P_USD: next_disp.value = consumed;
          P_DIF: begin
            next_disp.value = {4'h0, emax - emin};
            next_disp.cyl = idev + 3'h1;
            next_disp.dot = 1'b1;
          end
          P_CLD: begin
            next_disp.value = {8'h00, cmax};
            next_disp.cyl = icool + 3'h1;
          end
          default: next_disp.value = 16'h0000;
        endcase
        if (ALARM_I) begin
          next_disp.param = ALARM_CODE_I;
          next_disp.alarm = 1'b1;
          next_disp.flash = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) DISP_O <= '0;
    else DISP_O <= next_disp;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_accept;
    ui == UI_QUERY && step_tap && choice != CH_NO && !unit_evt;
  endsequence
  AST_UNIT_LEFT: assert property (
    unit_evt && !apply && fuel_left != 16'h0000 |=> fuel_left == $past(fuel_left) - 16'h0001)
    else $error("remaining fuel did not drop by one unit");
  AST_UNIT_USED: assert property (
    unit_evt && !apply && !zero_evt && consumed != 16'hffff |=> consumed == $past(consumed) + 16'h0001)
    else $error("used total did not rise by one unit");
  AST_PROMPT: assert property (
    ui == UI_FUEL |=> ui == UI_FUEL || (ui == UI_QUERY && choice == CH_NO))
    else $error("prompt left without a default no answer");
  AST_EXIT_NO: assert property (
    ui == UI_QUERY && step_tap && choice == CH_NO && !unit_evt |=> ui == UI_RUN && $stable(fuel_left))
    else $error("advance tap on no changed remaining fuel");
  AST_CHOICE: assert property (
    ui == UI_QUERY && !step_tap && sec_tap && choice != CH_PLUS |=> choice == $past(choice) + 2'b01)
    else $error("second button did not step the fill choice");
  AST_FILL_MAIN: assert property (
    s_accept and choice == CH_MAIN |=> fuel_left ==
      (($past(main_q) > $past(burned)) ? $past(main_q) - $past(burned) : 16'h0000))
    else $error("main fill did not subtract burned fuel");
  AST_FILL_PLUS: assert property (
    s_accept and choice == CH_PLUS |=> fuel_left == $past(edit) ##1 ui == UI_RUN)
    else $error("partial fill value not taken as entered");
  AST_USED_CLR: assert property (
    s_accept and !ctrl[`C_TRIP_TOTALIZER_SETTING] |=> consumed == 16'h0000)
    else $error("refuel did not clear used total");
  AST_USED_ACC: assert property (
    s_accept and ctrl[`C_TRIP_TOTALIZER_SETTING] && !zero_evt |=> $stable(consumed))
    else $error("accumulate lost the used total");
  AST_ZERO: assert property (
    zero_evt && !unit_evt |-> ##1 consumed == 16'h0000 ##1 DISP_O.msg == MSG_ZEROED)
    else $error("two-button hold did not zero used");
  AST_CRB: assert property (
    ui == UI_RUN && ctrl[`C_CDT] && $past(ctrl[`C_CDT]) |=> param != 5'(P_CRB))
    else $error("carburetor temperature scanned with outlet probe");
  AST_ALARM: assert property (
    ui == UI_RUN && ALARM_I |=> DISP_O.alarm && DISP_O.param == $past(ALARM_CODE_I))
    else $error("alarm not shown in digital display");
endmodule : fuel_totalizer_scan_select
`default_nettype wire

// >>> tb/fuel_pilot_model.sv
/*
  Turbine transducer model: emits a burst of pulses on request.
  Assumes go_i is high for one cycle with n_i stable beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module fuel_pilot_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] n_i,
  output logic pulse_o
);
  logic [7:0] left = 8'h00;
  logic [3:0] ph = 4'h0;
  // Five high, five low: slow enough that the input filter drops none
  always @(posedge clk_i) begin
    if (go_i) begin
      left <= n_i;
      ph <= 4'h0;
    end else if (left != 8'h00) begin
      ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
      if (ph == 4'h9) left <= left - 8'h01;
    end
  end
  assign pulse_o = (left != 8'h00) && (ph < 4'h5);
endmodule : fuel_pilot_model
`default_nettype wire

// >>> tb/fuel_totalizer_scan_select_tb.sv
/*
  Self-checking bench: refuel prompt, totals and scan filtering.
  Assumes a 4-cycle tick so the long prompt and hold counts stay short.
*/
`timescale 1ns/1ps
`default_nettype none
module fuel_totalizer_scan_select_tb;
  import fuel_pkg::*;
  logic clk = 1'b0;
  logic rst_n, pulse, step, sec, alarm, go;
  logic [1:0] sel;
  logic [4:0] acode;
  logic [7:0] n;
  logic [71:0] egt;
  logic [47:0] cool;
  logic [31:0] rdata, d, mv, av, ctrl;
  bus_req_t bus;
  disp_t disp;
  int n_fail = 0;
  int checked = 0;
  int seed = 32'h1773;
  int k, i;
  always #5 clk = ~clk;
  fuel_totalizer_scan_select #(.TICK_CYCLES(4)) i_dut (.CLK_I(clk), .RST_N_I(rst_n),
    .BUS_I(bus), .RDATA_O(rdata), .FLOW_PULSE_I(pulse), .STEP_BTN_I(step),
    .SECOND_BTN_I(sec), .SELECT_POS_I(sel), .ALARM_I(alarm), .ALARM_CODE_I(acode),
    .EGT_I(egt), .COOL_I(cool), .DISP_O(disp));
  fuel_pilot_model i_far (.clk_i(clk), .go_i(go), .n_i(n), .pulse_o(pulse));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 v = rdata;
  endtask : rd
  task automatic press(input logic s, input logic t, input int hold);
    @(posedge clk) {step, sec} <= {s, t};
    repeat (hold) @(posedge clk);
    {step, sec} <= 2'b00;
    repeat (10) @(posedge clk);
    // Step off the edge so callers see settled outputs
    #1;
  endtask : press
  function automatic logic [31:0] exp_fill(input logic [31:0] v, input logic [31:0] b);
    return (v > b) ? v - b : 32'h0;
  endfunction : exp_fill
  function automatic logic [31:0] exp_span(input logic [71:0] e);
    logic [11:0] hi, lo;
    hi = e[11:0];
    lo = e[11:0];
    for (int c = 1; c < 6; c++) begin
      if (e[c*12 +: 12] > hi) hi = e[c*12 +: 12];
      if (e[c*12 +: 12] < lo) lo = e[c*12 +: 12];
    end
    return {20'h0, hi - lo};
  endfunction : exp_span
  task automatic give_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  function automatic logic ok_param(input logic [4:0] p, input logic [1:0] s,
                                    input logic [5:0] c);
    logic fuel;
    fuel = (p >= 5'd7) && (p <= 5'd14);
    if (p == 5'd5 && c[1]) return 1'b0;
    if ((p == 5'd9 || p == 5'd10) && !(c[2] && c[3])) return 1'b0;
    if (p == 5'd11 && !c[2]) return 1'b0;
    return (s == 2'b00) ? (!fuel || p == 5'd7) : (s == 2'b10) ? fuel : 1'b1;
  endfunction : ok_param
  // ----------------------------------------
  // Main sequence: pass 0 main fill, pass 1 both tanks with accumulate
  // ----------------------------------------
  initial begin
    {rst_n, step, sec, alarm, go, n, acode} = '0;
    bus = '0;
    sel = 2'b01;
    egt = 72'({$random(seed), $random(seed), $random(seed)});
    cool = 48'({$random(seed), $random(seed)});
    for (k = 0; k < 2; k++) begin
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 chk(32'(disp.msg), 32'(MSG_FUEL));
      rd(8'h0c, d);
      chk(d, 32'h1);
      // Read data stand one cycle only
      @(posedge clk);
      #1 chk(rdata, 32'h0);
      rd(8'h30, d);
      chk(d, 32'h0);
      mv = $random(seed) & 32'h0fff;
      av = $random(seed) & 32'h0fff;
      ctrl = ($random(seed) & 32'h0e) | k;
      wr(8'h04, mv);
      wr(8'h08, av);
      wr(8'h00, ctrl);
      wr(8'h0c, 32'h2);
      @(posedge clk) {go, n} <= {1'b1, 8'h06};
      @(posedge clk) go <= 1'b0;
      repeat (80) @(posedge clk);
      rd(8'h18, d);
      chk(d, 32'h3);
      for (i = 0; i < 5000 && disp.msg !== MSG_FILL; i++) @(posedge clk);
      #1;
      if (disp.msg !== MSG_FILL) begin
        n_fail++;
        give_verdict;
      end
      chk(32'(disp.choice), 32'(CH_NO));
      press(1'b0, 1'b1, 6);
      chk(32'(disp.choice), 32'(CH_MAIN));
      if (k == 1) press(1'b0, 1'b1, 6);
      rd(8'h14, d);
      chk(d, 32'h0);
      press(1'b1, 1'b0, 6);
      rd(8'h14, d);
      chk(d, exp_fill(k == 1 ? mv + av : mv, 32'h3));
      rd(8'h18, d);
      chk(d, k == 1 ? 32'h3 : 32'h0);
      for (i = 0; i < 24; i++) begin
        @(posedge clk) sel <= 2'($random(seed));
        repeat (8) @(posedge clk);
        press(1'b1, 1'b0, 6);
        chk(32'(ok_param(disp.param, sel, ctrl[5:0])), 32'h1);
      end
      @(posedge clk) {alarm, acode} <= {1'b1, 5'd13};
      repeat (3) @(posedge clk);
      #1 chk(32'(disp.alarm), 32'h1);
      @(posedge clk) {alarm, sel} <= {1'b0, 2'b01};
      repeat (8) @(posedge clk);
      for (i = 0; i < 25 && disp.param !== 5'd14; i++) begin
        press(1'b1, 1'b0, 6);
        if (disp.param === 5'd6) chk(32'(disp.value), exp_span(egt));
      end
      if (disp.param !== 5'd14) begin
        n_fail++;
        give_verdict;
      end
      if (k == 1) press(1'b1, 1'b1, 20010);
      rd(8'h18, d);
      chk(d, 32'h0);
      #1;
      if (k == 1) chk(32'(disp.msg), 32'(MSG_ZEROED));
    end
    give_verdict;
  end
endmodule : fuel_totalizer_scan_select_tb
`default_nettype wire
